// ===== hsda_map.vh
// hsda_map.vh: constants for the host sram / dma arbiter
// assumes inclusion by bare name from the design files
`ifndef HSDA_MAP_VH
`define HSDA_MAP_VH

`define HSDA_MEM_DEPTH       4096
`define HSDA_REG_TOP         12'h03F
`define HSDA_SHARED_REG_BASE 12'hFC0
`define HSDA_SHARED_MEM_TOP  12'hFBF

`define HSDA_FCW_BCAST_BIT   7
`define HSDA_FCW_SAP_BIT     6
`define HSDA_FCW_DTYPE_HI    5
`define HSDA_FCW_DTYPE_LO    4
`define HSDA_FCW_CODE_HI     3
`define HSDA_FCW_CODE_LO     0

`define HSDA_DTYPE_NODE      2'h0
`define HSDA_DTYPE_SERVER    2'h1
`define HSDA_DTYPE_HIGHER    2'h2

`define HSDA_CH_RX           2'h0
`define HSDA_CH_TX           2'h1
`define HSDA_CH_LOOKUP       2'h2

`endif

// ===== hsda_sram.v
// hsda_sram.v: single-port byte-wide buffer memory, one access per cycle
// assumes one master drives it at a time; read data comes from a register
`timescale 1ns/1ns
`default_nettype none
`include "hsda_map.vh"
module hsda_sram #(
    parameter ADDR_W = 12,
    parameter DATA_W = 8,
    parameter DEPTH  = `HSDA_MEM_DEPTH
) (
    input  wire              ref_clk_i,
    input  wire              en_i,
    input  wire              we_i,
    input  wire [ADDR_W-1:0] addr_i,
    input  wire [DATA_W-1:0] wdata_i,
    output reg  [DATA_W-1:0] rdata_o
);
    reg [DATA_W-1:0] mem [0:DEPTH-1];

    always @(posedge ref_clk_i)
    begin
        if (en_i)
        begin
            if (we_i)
                mem[addr_i] <= wdata_i;
            else
                rdata_o <= mem[addr_i];
        end
    end
endmodule
`default_nettype wire

// ===== hsda_arbiter.v
// hsda_arbiter.v: host port decode, sram arbiter, three-channel dma, recognizer
// assumes asynchronous host strobes and a system clock of 100 MHz
`timescale 1ns/1ns
`default_nettype none
`include "hsda_map.vh"
module hsda_arbiter #(
    parameter ADDR_W = 12,
    parameter DATA_W = 8,
    parameter DIV_W  = 8,
    parameter LEN_W  = 8
) (
    input  wire              ref_clk_i,
    input  wire              resetn_i,
    input  wire [ADDR_W-1:0] host_addr_bus_i,
    input  wire [DATA_W-1:0] host_data_bus_i,
    output reg  [DATA_W-1:0] host_data_bus_o,
    output wire              host_data_bus_oe_o,
    input  wire              mem_select_low_i,
    input  wire              reg_select_low_i,
    input  wire              host_write_strobe_low_i,
    input  wire              host_read_strobe_low_i,
    output wire              host_wait_pin_o,
    output wire              host_wait_pin_oe_o,
    output wire              irq_out_low_o,
    input  wire              addr_mode_shared_i,
    output reg               reg_wr_o,
    output reg               reg_rd_o,
    output reg  [5:0]        reg_addr_o,
    output reg  [DATA_W-1:0] reg_wdata_o,
    input  wire [DATA_W-1:0] reg_rdata_i,
    input  wire              rx_dma_req_i,
    input  wire [ADDR_W-1:0] rx_dma_addr_i,
    input  wire [DATA_W-1:0] rx_dma_data_i,
    output wire              rx_dma_ack_o,
    input  wire              tx_dma_req_i,
    input  wire [ADDR_W-1:0] tx_dma_addr_i,
    output wire [DATA_W-1:0] tx_dma_data_o,
    output wire              tx_dma_ack_o,
    input  wire              line_clk_i,
    input  wire              clk_source_sel_i,
    input  wire [DIV_W-1:0]  clk_div_i,
    input  wire              addr_recog_enable_i,
    input  wire [7:0]        node_identifier_i,
    input  wire [ADDR_W-1:0] table_base_i,
    input  wire [LEN_W-1:0]  table_len_i,
    input  wire              frame_valid_i,
    input  wire [7:0]        frame_ctrl_word_i,
    input  wire [7:0]        dest_addr_i,
    output reg  [7:0]        frame_ctrl_word_o,
    output reg               broadcast_o,
    output reg               source_addr_present_o,
    output reg  [3:0]        frame_code_o,
    output reg  [1:0]        dest_type_o,
    output reg               addr_match_irq_o,
    output reg               table_done_irq_o,
    input  wire [1:0]        irq_clear_i
);
    localparam SYNC_W = 4 + ADDR_W + DATA_W + 1;
    localparam ST_IDLE = 2'h0;
    localparam ST_CPU  = 2'h1;
    localparam ST_DMA  = 2'h2;
    localparam ST_DACK = 2'h3;
    localparam RS_IDLE = 2'h0;
    localparam RS_LOOK = 2'h1;

    function [1:0] hsda_decode;
        input            shared;
        input            rsel;
        input            msel;
        input [ADDR_W-1:0] a;
        begin
            if (shared)
                hsda_decode = (rsel | msel) ?
                    ((a >= `HSDA_SHARED_REG_BASE) ? 2'h2 : 2'h1) : 2'h0;
            else
                hsda_decode = {rsel & ~msel, msel & ~rsel};
        end
    endfunction

    reg  [SYNC_W-1:0] sync1;
    reg  [SYNC_W-1:0] sync2;
    reg               wr_q;
    reg               rd_q;
    reg               lclk_q;
    reg  [1:0]        state;
    reg  [1:0]        cpu_phase;
    reg  [1:0]        dma_sel;
    reg  [1:0]        rstate;
    reg               pending;
    reg  [7:0]        fcw_l;
    reg  [7:0]        dest_l;
    reg  [LEN_W-1:0]  idx;
    reg  [DIV_W-1:0]  div_cnt;
    reg               mem_en;
    reg               mem_we;
    reg  [ADDR_W-1:0] mem_addr;
    reg  [DATA_W-1:0] mem_wdata;
    wire [DATA_W-1:0] mem_rdata;

    // host pins are asynchronous: two flops before any use
    always @(posedge ref_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            sync1 <= {SYNC_W{1'b0}};
            sync2 <= {SYNC_W{1'b0}};
        end
        else
        begin
            sync1 <= {~mem_select_low_i, ~reg_select_low_i, ~host_write_strobe_low_i,
                      ~host_read_strobe_low_i, host_addr_bus_i, host_data_bus_i,
                      line_clk_i};
            sync2 <= sync1;
        end
    end

    wire              msel_s = sync2[SYNC_W-1];
    wire              rsel_s = sync2[SYNC_W-2];
    wire              wr_s   = sync2[SYNC_W-3];
    wire              rd_s   = sync2[SYNC_W-4];
    wire [ADDR_W-1:0] addr_s = sync2[DATA_W+ADDR_W:DATA_W+1];
    wire [DATA_W-1:0] data_s = sync2[DATA_W:1];
    wire              lclk_s = sync2[0];
    wire [1:0]        hit    = hsda_decode(addr_mode_shared_i, rsel_s, msel_s, addr_s);
    wire              cpu_mem_req = hit[0] & (wr_s | rd_s);
    wire              lk_req = (rstate == RS_LOOK);
    wire              any_dma = rx_dma_req_i | tx_dma_req_i | lk_req;
    wire              lk_ack = (state == ST_DACK) && (dma_sel == `HSDA_CH_LOOKUP);
    wire              host_wait = cpu_mem_req &
                                  ~((state == ST_CPU) && (cpu_phase == 2'h2));

    // pin pulls low or floats, never drives high
    assign host_wait_pin_o    = 1'b0;
    assign host_wait_pin_oe_o = host_wait;
    assign host_data_bus_oe_o = rd_s & (hit[0] | hit[1]);
    assign rx_dma_ack_o  = (state == ST_DACK) && (dma_sel == `HSDA_CH_RX);
    assign tx_dma_ack_o  = (state == ST_DACK) && (dma_sel == `HSDA_CH_TX);
    assign tx_dma_data_o = mem_rdata;
    assign irq_out_low_o = ~(addr_match_irq_o | table_done_irq_o);

    always @*
    begin
        mem_en    = 1'b0;
        mem_we    = 1'b0;
        mem_addr  = addr_s;
        mem_wdata = data_s;
        if (state == ST_CPU)
        begin
            mem_en = (cpu_phase == 2'h0);
            mem_we = wr_s;
        end
        else if (state == ST_DMA)
        begin
            mem_en = 1'b1;
            case (dma_sel)
                `HSDA_CH_RX:
                begin
                    mem_we    = 1'b1;
                    mem_addr  = rx_dma_addr_i;
                    mem_wdata = rx_dma_data_i;
                end
                `HSDA_CH_TX:     mem_addr = tx_dma_addr_i;
                `HSDA_CH_LOOKUP: mem_addr = table_base_i + {{(ADDR_W-LEN_W){1'b0}}, idx};
                default:         mem_en = 1'b0;
            endcase
        end
    end

    hsda_sram #(
        .ADDR_W (ADDR_W),
        .DATA_W (DATA_W)
    ) u_sram (
        .ref_clk_i (ref_clk_i),
        .en_i      (mem_en),
        .we_i      (mem_we),
        .addr_i    (mem_addr),
        .wdata_i   (mem_wdata),
        .rdata_o   (mem_rdata)
    );

    // arbiter; one dma byte per grant, but in idle any dma request wins over a waiting host
    always @(posedge ref_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            state     <= ST_IDLE;
            cpu_phase <= 2'h0;
            dma_sel   <= `HSDA_CH_RX;
        end
        else
        begin
            case (state)
                ST_IDLE:
                begin
                    cpu_phase <= 2'h0;
                    if (any_dma)
                    begin
                        state <= ST_DMA;
                        if (rx_dma_req_i)
                            dma_sel <= `HSDA_CH_RX;
                        else if (lk_req)
                            dma_sel <= `HSDA_CH_LOOKUP;
                        else
                            dma_sel <= `HSDA_CH_TX;
                    end
                    else if (cpu_mem_req)
                        state <= ST_CPU;
                end
                ST_CPU:
                begin
                    if (cpu_phase != 2'h2)
                        cpu_phase <= cpu_phase + 2'h1;
                    if (!cpu_mem_req)
                        state <= ST_IDLE;
                end
                ST_DMA:  state <= ST_DACK;
                ST_DACK: state <= ST_IDLE;
                default: state <= ST_IDLE;
            endcase
        end
    end

    // register port and host read data
    always @(posedge ref_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            wr_q            <= 1'b0;
            rd_q            <= 1'b0;
            reg_wr_o        <= 1'b0;
            reg_rd_o        <= 1'b0;
            reg_addr_o      <= 6'h00;
            reg_wdata_o     <= {DATA_W{1'b0}};
            host_data_bus_o <= {DATA_W{1'b0}};
        end
        else
        begin
            wr_q        <= wr_s;
            rd_q        <= rd_s;
            reg_wr_o    <= hit[1] & wr_s & ~wr_q;
            reg_rd_o    <= hit[1] & rd_s & ~rd_q;
            reg_addr_o  <= addr_s[5:0];
            reg_wdata_o <= data_s;
            if (hit[1] & rd_s)
                host_data_bus_o <= reg_rdata_i;
            else if ((state == ST_CPU) && (cpu_phase == 2'h1) && rd_s)
                host_data_bus_o <= mem_rdata;
        end
    end

    // recognition tick: divided system clock or line clock edge
    wire tick = clk_source_sel_i ? (lclk_s & ~lclk_q) : (div_cnt == clk_div_i);
    wire [1:0] dtype = fcw_l[`HSDA_FCW_DTYPE_HI:`HSDA_FCW_DTYPE_LO];

    always @(posedge ref_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            lclk_q                <= 1'b0;
            div_cnt               <= {DIV_W{1'b0}};
            rstate                <= RS_IDLE;
            pending               <= 1'b0;
            fcw_l                 <= 8'h00;
            dest_l                <= 8'h00;
            idx                   <= {LEN_W{1'b0}};
            frame_ctrl_word_o     <= 8'h00;
            broadcast_o           <= 1'b0;
            source_addr_present_o <= 1'b0;
            frame_code_o          <= 4'h0;
            dest_type_o           <= 2'h0;
            addr_match_irq_o      <= 1'b0;
            table_done_irq_o      <= 1'b0;
        end
        else
        begin
            lclk_q  <= lclk_s;
            div_cnt <= (div_cnt == clk_div_i) ? {DIV_W{1'b0}} : div_cnt + 1'b1;
            // clears first so a same-cycle set below wins
            if (irq_clear_i[0])
                addr_match_irq_o <= 1'b0;
            if (irq_clear_i[1])
                table_done_irq_o <= 1'b0;
            if (frame_valid_i)
            begin
                pending <= 1'b1;
                fcw_l   <= frame_ctrl_word_i;
                dest_l  <= dest_addr_i;
            end
            case (rstate)
                RS_IDLE:
                begin
                    if (pending && tick && !frame_valid_i)
                    begin
                        pending               <= 1'b0;
                        frame_ctrl_word_o     <= fcw_l;
                        broadcast_o           <= fcw_l[`HSDA_FCW_BCAST_BIT];
                        source_addr_present_o <= fcw_l[`HSDA_FCW_SAP_BIT];
                        frame_code_o          <= fcw_l[`HSDA_FCW_CODE_HI:`HSDA_FCW_CODE_LO];
                        dest_type_o           <= dtype;
                        idx                   <= {LEN_W{1'b0}};
                        if (addr_recog_enable_i)
                        begin
                            if (dtype == `HSDA_DTYPE_NODE)
                            begin
                                if (dest_l == node_identifier_i)
                                    addr_match_irq_o <= 1'b1;
                            end
                            else if ((dtype == `HSDA_DTYPE_SERVER) ||
                                     (dtype == `HSDA_DTYPE_HIGHER))
                            begin
                                if (table_len_i == {LEN_W{1'b0}})
                                    table_done_irq_o <= 1'b1;
                                else
                                    rstate <= RS_LOOK;
                            end
                        end
                    end
                end
                RS_LOOK:
                begin
                    if (lk_ack)
                    begin
                        if (mem_rdata == dest_l)
                        begin
                            addr_match_irq_o <= 1'b1;
                            table_done_irq_o <= 1'b1;
                            rstate           <= RS_IDLE;
                        end
                        else if (idx + 1'b1 == table_len_i)
                        begin
                            table_done_irq_o <= 1'b1;
                            rstate           <= RS_IDLE;
                        end
                        idx <= idx + 1'b1;
                    end
                end
                default: rstate <= RS_IDLE;
            endcase
        end
    end
endmodule
`default_nettype wire

// ===== hsda_arb_chk.sv
// hsda_arb_chk.sv: port-level assertions for the host sram / dma arbiter
// assumes a bind onto hsda_arbiter, one clock, asynchronous active-low reset
`timescale 1ns/1ns
`default_nettype none
module hsda_arb_chk (
    input wire logic       ref_clk_i,
    input wire logic       resetn_i,
    input wire logic       mem_select_low_i,
    input wire logic       reg_select_low_i,
    input wire logic       host_wait_pin_o,
    input wire logic       host_wait_pin_oe_o,
    input wire logic       irq_out_low_o,
    input wire logic       reg_wr_o,
    input wire logic       reg_rd_o,
    input wire logic       rx_dma_ack_o,
    input wire logic       tx_dma_req_i,
    input wire logic       tx_dma_ack_o,
    input wire logic       addr_recog_enable_i,
    input wire logic [7:0] frame_ctrl_word_o,
    input wire logic       broadcast_o,
    input wire logic       source_addr_present_o,
    input wire logic [3:0] frame_code_o,
    input wire logic [1:0] dest_type_o,
    input wire logic       addr_match_irq_o,
    input wire logic       table_done_irq_o
);
    logic desel;
    // two sync stages, so a deselect is trusted only after four samples
    assign desel = mem_select_low_i & reg_select_low_i;
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!resetn_i);
    AST_WAIT_LEVEL: assert property (host_wait_pin_oe_o |-> host_wait_pin_o == 1'b0)
        else $error("wait pin driven high");
    AST_WAIT_MIN: assert property ($rose(host_wait_pin_oe_o) |=> host_wait_pin_oe_o [*2])
        else $error("wait released too early");
    AST_WAIT_MAX: assert property ($rose(host_wait_pin_oe_o) |-> ##[1:40] !host_wait_pin_oe_o)
        else $error("wait held too long");
    AST_IDLE_NO_WAIT: assert property (desel && $past(desel) && $past(desel, 2)
        && $past(desel, 3) |-> !host_wait_pin_oe_o) else $error("wait without host access");
    AST_REG_NO_WAIT: assert property ((reg_wr_o || reg_rd_o) |-> !host_wait_pin_oe_o)
        else $error("wait on register access");
    AST_IRQ_PIN: assert property (irq_out_low_o == !(addr_match_irq_o || table_done_irq_o))
        else $error("interrupt pin wrong");
    AST_ACK_ONCE: assert property (rx_dma_ack_o |=> !rx_dma_ack_o)
        else $error("rx ack longer than one cycle");
    AST_ONE_OWNER: assert property (!(rx_dma_ack_o && tx_dma_ack_o))
        else $error("two channels served at once");
    AST_TX_LAT: assert property ($rose(tx_dma_req_i) |-> !tx_dma_ack_o ##1 !tx_dma_ack_o
        ##[1:30] tx_dma_ack_o) else $error("tx ack timing wrong");
    AST_DECODE: assert property (broadcast_o == frame_ctrl_word_o[7]
        && source_addr_present_o == frame_ctrl_word_o[6] && dest_type_o == frame_ctrl_word_o[5:4]
        && frame_code_o == frame_ctrl_word_o[3:0]) else $error("decoded fields disagree");
    AST_MATCH_EN: assert property ($rose(addr_match_irq_o) |-> $past(addr_recog_enable_i))
        else $error("match while recognition off");
endmodule
bind hsda_arbiter hsda_arb_chk u_chk (
    .ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .mem_select_low_i(mem_select_low_i),
    .reg_select_low_i(reg_select_low_i), .host_wait_pin_o(host_wait_pin_o),
    .host_wait_pin_oe_o(host_wait_pin_oe_o), .irq_out_low_o(irq_out_low_o),
    .reg_wr_o(reg_wr_o), .reg_rd_o(reg_rd_o), .rx_dma_ack_o(rx_dma_ack_o),
    .tx_dma_req_i(tx_dma_req_i), .tx_dma_ack_o(tx_dma_ack_o),
    .addr_recog_enable_i(addr_recog_enable_i), .frame_ctrl_word_o(frame_ctrl_word_o),
    .broadcast_o(broadcast_o), .source_addr_present_o(source_addr_present_o),
    .frame_code_o(frame_code_o), .dest_type_o(dest_type_o),
    .addr_match_irq_o(addr_match_irq_o), .table_done_irq_o(table_done_irq_o));
`default_nettype wire

// ===== hsda_cpu_model.sv
// hsda_cpu_model.sv: behavioural host cpu on the parallel port
// assumes the bench resolves the pulled-up wait wire and calls acc
`timescale 1ns/1ns
`default_nettype none
module hsda_cpu_model (
    input  wire logic        ref_clk_i,
    input  wire logic        wait_n_i,
    input  wire logic [7:0]  rdata_i,
    output var  logic [11:0] addr_o,
    output var  logic [7:0]  wdata_o,
    output var  logic        mem_sel_low_o,
    output var  logic        reg_sel_low_o,
    output var  logic        wr_low_o,
    output var  logic        rd_low_o
);
    initial
    begin
        addr_o = 12'h000;
        wdata_o = 8'h00;
        {reg_sel_low_o, mem_sel_low_o} = 2'b11;
        wr_low_o = 1'b1;
        rd_low_o = 1'b1;
    end
    // sel is {register, memory}, both active low
    task automatic acc(input logic wr, input logic [1:0] sel, input logic [11:0] a,
                       input logic [7:0] d, output logic [7:0] q);
        int n;
        @(negedge ref_clk_i);
        addr_o = a;
        wdata_o = wr ? d : ~wdata_o;
        {reg_sel_low_o, mem_sel_low_o} = sel;
        wr_low_o = !wr;
        rd_low_o = wr;
        n = 0;
        // wait is meaningless before the synchronizer has caught the strobe
        do
        begin
            @(negedge ref_clk_i);
            n++;
        end
        while ((n < 5 || wait_n_i !== 1'b1) && n < 100);
        q = rdata_i;
        wr_low_o = 1'b1;
        rd_low_o = 1'b1;
        {reg_sel_low_o, mem_sel_low_o} = 2'b11;
        addr_o = ~a;
        wdata_o = ~wdata_o;
        repeat (4) @(negedge ref_clk_i);
    endtask
endmodule
`default_nettype wire

// ===== hsda_tb.sv
// hsda_tb.sv: self-checking bench for the host sram / dma arbiter
// assumes hsda_cpu_model as host and the bound checker
`timescale 1ns/1ns
`default_nettype none
module testbench;
    logic        ref_clk_i, resetn_i, doe, msel, rsel, wr_n, rd_n, wpin, woe, irq_n, shared;
    logic        reg_wr, rx_req, rx_ack, tx_req, tx_ack, en, fvalid, bc, sap, amatch, tdone;
    logic        reg_rd, lclk, csel;
    logic [7:0]  rd_cnt;
    logic [11:0] haddr, dma_addr, base;
    logic [7:0]  hwd, hrd_o, reg_wdata, rx_data, tx_data, div, node, len, fcw, dest, fcw_q;
    logic [7:0]  wr_cnt, wr_a, wr_d, q, q2;
    logic [5:0]  reg_addr;
    logic [3:0]  code;
    logic [1:0]  dtype, clr;
    int          error_cnt, checks;
    wire         wait_n = woe ? wpin : 1'b1;
    wire [7:0]   hrd = doe ? hrd_o : ~hrd_o;
    hsda_cpu_model cpu (.ref_clk_i(ref_clk_i), .wait_n_i(wait_n), .rdata_i(hrd),
        .addr_o(haddr), .wdata_o(hwd), .mem_sel_low_o(msel), .reg_sel_low_o(rsel),
        .wr_low_o(wr_n), .rd_low_o(rd_n));
    hsda_arbiter dut (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .host_addr_bus_i(haddr),
        .host_data_bus_i(hwd), .host_data_bus_o(hrd_o), .host_data_bus_oe_o(doe),
        .mem_select_low_i(msel), .reg_select_low_i(rsel), .host_write_strobe_low_i(wr_n),
        .host_read_strobe_low_i(rd_n), .host_wait_pin_o(wpin), .host_wait_pin_oe_o(woe),
        .irq_out_low_o(irq_n), .addr_mode_shared_i(shared), .reg_wr_o(reg_wr), .reg_rd_o(reg_rd),
        .reg_addr_o(reg_addr), .reg_wdata_o(reg_wdata), .reg_rdata_i(8'hA5),
        .rx_dma_req_i(rx_req), .rx_dma_addr_i(dma_addr), .rx_dma_data_i(rx_data),
        .rx_dma_ack_o(rx_ack), .tx_dma_req_i(tx_req), .tx_dma_addr_i(dma_addr),
        .tx_dma_data_o(tx_data), .tx_dma_ack_o(tx_ack), .line_clk_i(lclk),
        .clk_source_sel_i(csel), .clk_div_i(div), .addr_recog_enable_i(en),
        .node_identifier_i(node), .table_base_i(base), .table_len_i(len),
        .frame_valid_i(fvalid), .frame_ctrl_word_i(fcw), .dest_addr_i(dest),
        .frame_ctrl_word_o(fcw_q), .broadcast_o(bc), .source_addr_present_o(sap),
        .frame_code_o(code), .dest_type_o(dtype), .addr_match_irq_o(amatch),
        .table_done_irq_o(tdone), .irq_clear_i(clr));
    initial
    begin
        ref_clk_i = 1'b0;
        forever #5 ref_clk_i = ~ref_clk_i;
    end
    // line clock unrelated to the system clock, so edges fall anywhere in a cycle
    initial
    begin
        lclk = 1'b0;
        forever #37 lclk = ~lclk;
    end
    always @(posedge ref_clk_i)
        if (reg_rd === 1'b1)
            rd_cnt <= rd_cnt + 8'h01;
    always @(posedge ref_clk_i)
        if (reg_wr === 1'b1)
        begin
            wr_cnt <= wr_cnt + 8'h01;
            wr_a <= {2'b00, reg_addr};
            wr_d <= reg_wdata;
        end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // one byte on a dma channel; request dropped in the cycle after ack
    task automatic dma(input logic tx, input logic [11:0] a, input logic [7:0] d,
                       output logic [7:0] r);
        int n;
        @(negedge ref_clk_i);
        dma_addr = a;
        rx_data = d;
        tx_req = tx;
        rx_req = !tx;
        n = 0;
        while ((tx ? tx_ack : rx_ack) !== 1'b1 && n < 50)
        begin
            @(negedge ref_clk_i);
            n++;
        end
        r = tx_data;
        @(negedge ref_clk_i);
        tx_req = 1'b0;
        rx_req = 1'b0;
        rx_data = ~d;
        dma_addr = ~a;
    endtask
    task automatic frame(input logic [7:0] w, input logic [7:0] da);
        @(negedge ref_clk_i);
        fcw = w;
        dest = da;
        fvalid = 1'b1;
        @(negedge ref_clk_i);
        fvalid = 1'b0;
        fcw = ~w;
        dest = ~da;
        repeat (100) @(negedge ref_clk_i);
    endtask
    task automatic clear_irq();
        @(negedge ref_clk_i);
        clr = 2'b11;
        @(negedge ref_clk_i);
        clr = 2'b00;
    endtask
    task automatic wrap_up();
        $display("checks=%0d error_cnt=%0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial
    begin
        #100000;
        error_cnt++;
        $display("BAD t=%0t got=%h exp=%h", $time, 8'h00, 8'h01);
        wrap_up();
    end
    initial
    begin
        {resetn_i, shared, rx_req, tx_req, en, fvalid} = 6'h00;
        {error_cnt, checks} = {32'd0, 32'd0};
        {dma_addr, rx_data, fcw, dest, clr, wr_cnt, wr_a, wr_d} = 62'h0;
        {div, node, base, len} = {8'h03, 8'h2C, 12'h200, 8'h03};
        {csel, rd_cnt} = 9'h000;
        repeat (10) @(negedge ref_clk_i);
        resetn_i = 1'b1;
        cpu.acc(1'b1, 2'b10, 12'hFFF, 8'h5A, q);
        cpu.acc(1'b1, 2'b10, 12'h000, 8'hC3, q);
        cpu.acc(1'b0, 2'b10, 12'hFFF, 8'h00, q);
        chk(q, 8'h5A);
        cpu.acc(1'b1, 2'b01, 12'hFFF, 8'h96, q);
        chk(wr_a, 8'h3F);
        chk(wr_d, 8'h96);
        cpu.acc(1'b0, 2'b01, 12'h012, 8'h00, q);
        chk(q, 8'hA5);
        chk(rd_cnt, 8'h01);
        cpu.acc(1'b1, 2'b00, 12'h010, 8'h11, q);
        chk(wr_cnt, 8'h01);
        $display("test separate done");
        shared = 1'b1;
        cpu.acc(1'b1, 2'b00, 12'hFC5, 8'h77, q);
        chk(wr_a, 8'h05);
        cpu.acc(1'b1, 2'b00, 12'hFBF, 8'hE1, q);
        chk(wr_cnt, 8'h02);
        cpu.acc(1'b0, 2'b00, 12'hFBF, 8'h00, q);
        chk(q, 8'hE1);
        cpu.acc(1'b0, 2'b00, 12'h000, 8'h00, q);
        chk(q, 8'hC3);
        $display("test shared done");
        dma(1'b1, 12'hFBF, 8'h00, q);
        chk(q, 8'hE1);
        dma(1'b0, 12'h123, 8'h3C, q);
        dma(1'b1, 12'h123, 8'h00, q);
        chk(q, 8'h3C);
        fork
            cpu.acc(1'b0, 2'b00, 12'h123, 8'h00, q);
            begin
                repeat (2) @(negedge ref_clk_i);
                dma(1'b0, 12'h123, 8'h4B, q2);
            end
        join
        chk(q, 8'h4B);
        $display("test dma done");
        for (int i = 0; i < 3; i++)
            cpu.acc(1'b1, 2'b00, 12'h200 + 12'(i), 8'h40 + 8'(i), q);
        en = 1'b1;
        frame(8'h05, 8'h2C);
        chk({6'h00, amatch, irq_n}, 8'h02);
        clear_irq();
        en = 1'b0;
        frame(8'h05, 8'h2C);
        chk({6'h00, amatch, tdone}, 8'h00);
        en = 1'b1;
        frame(8'hD3, 8'h42);
        chk({bc, sap, dtype, code}, 8'hD3);
        chk(fcw_q, 8'hD3);
        chk({6'h00, amatch, tdone}, 8'h03);
        clear_irq();
        frame(8'h25, 8'h99);
        chk({6'h00, amatch, tdone}, 8'h01);
        clear_irq();
        len = 8'h00;
        csel = 1'b1;
        frame(8'h15, 8'h40);
        chk({6'h00, amatch, tdone}, 8'h01);
        $display("test recognizer done");
        wrap_up();
    end
endmodule
`default_nettype wire
